// *** include/wds_pkg.sv ***
/*
 * wds_pkg: constants shared by the watchdog supervisor block.
 * Assumes a single 25 MHz clock; periods are scaled from a capacitance
 * figure in nanofarads so the documented per-nanofarad slopes stay exact.
 */
`default_nettype none
package wds_pkg;
	localparam int unsigned WDS_CLK_HZ        = 25_000_000;
	// watchdog slope: 25 ms per nF, held as 25000 us per nF
	localparam int unsigned WDS_WD_US_PER_NF  = 25_000;
	// reset slope: 3.125 ms per nF, held as 3125 us per nF
	localparam int unsigned WDS_RST_US_PER_NF = 3_125;
	localparam int unsigned WDS_CAP_NF_DFLT   = 64;
	localparam int unsigned WDS_CNT_W         = 32;
	localparam int unsigned WDS_SYNC_STAGES   = 2;

	function automatic longint unsigned wds_cycles(
		input longint unsigned us_per_nf,
		input longint unsigned cap_nf
	);
		longint unsigned c;
		c = (us_per_nf * cap_nf * WDS_CLK_HZ) / 64'd1_000_000;
		wds_cycles = (c == 64'd0) ? 64'd1 : c;
	endfunction
endpackage
`default_nettype wire

// *** rtl/wds_period_timer.sv ***
/*
 * wds_period_timer: restartable down counter that pulses done once.
 * Assumes synchronous restart/hold inputs on the one block clock.
 */
`timescale 1ns/1ns
`default_nettype none
module wds_period_timer
	import wds_pkg::*;
#(
	parameter int unsigned CNT_W = WDS_CNT_W
)(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [CNT_W-1:0] period,
	input  wire logic             restart,
	input  wire logic             hold,
	output var  logic             done
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             done_r;
	logic             done_nxt;

	assign done = done_r;

	always_comb
	begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (restart || hold)
		begin
			cnt_nxt = period;
		end
		else if (cnt_r > {{(CNT_W-1){1'b0}}, 1'b1})
		begin
			cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
		end
		else if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
		begin
			// expiry fires once; zero parks the timer until restarted
			cnt_nxt  = '0;
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r  <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end
endmodule
`default_nettype wire

// *** rtl/wds_watchdog_supervisor.sv ***
/*
 * wds_watchdog_supervisor: watchdog and reset-hold logic of a processor
 * supervisor. kick_input comes from a processor I/O line; the reset
 * condition is a level from the (out of scope) threshold sensor.
 * Assumes one free-running clock and an asynchronous power-on rst_n.
 */
// Behaviour
// - watchdog period scales 25 ms per nF
// - either kick edge counts; processor must kick
// - expiry drives fault low until kick/reset
// - reset output forces fault high, restarts period
// - kick during fault releases it, restarts period
// - new period starts when reset releases
// - any reset trigger holds reset full period
// - reset and fault are separate outputs; reset holds fault high
// - reset hold period scales 3.125 ms per nF
`timescale 1ns/1ns
`default_nettype none
module wds_watchdog_supervisor
	import wds_pkg::*;
#(
	parameter int unsigned CNT_W     = WDS_CNT_W,
	parameter int unsigned WD_CAP_NF = WDS_CAP_NF_DFLT,
	parameter int unsigned RP_CAP_NF = WDS_CAP_NF_DFLT,
	// cycle counts exceed 4096, so both are overridable for simulation
	parameter logic [CNT_W-1:0] WD_CYCLES =
		CNT_W'(wds_cycles(WDS_WD_US_PER_NF, WD_CAP_NF)),
	parameter logic [CNT_W-1:0] RP_CYCLES =
		CNT_W'(wds_cycles(WDS_RST_US_PER_NF, RP_CAP_NF))
)(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic kick_input,
	input  wire logic reset_trigger,
	output var  logic supervisor_reset_n,
	output var  logic watchdog_fault_n
);
	logic [WDS_SYNC_STAGES-1:0] kick_sync_r;
	logic [WDS_SYNC_STAGES-1:0] kick_sync_nxt;
	logic                       kick_prev_r;
	logic                       kick_prev_nxt;
	logic                       kick_edge;
	logic                       rst_hold_r;
	logic                       rst_hold_nxt;
	logic                       rst_done;
	logic                       wd_done;
	logic                       fault_r;
	logic                       fault_nxt;
	logic                       reset_out_r;
	logic                       reset_out_nxt;
	// power-on acts as a trigger: loads the hold timer once after rst_n
	logic                       pwr_start_r;
	logic                       pwr_start_nxt;
	logic                       rst_load;

	assign supervisor_reset_n = reset_out_r;
	assign watchdog_fault_n   = fault_r;

	// kick synchroniser; only the last stage feeds the edge compare
	always_comb
	begin
		kick_sync_nxt = {kick_sync_r[WDS_SYNC_STAGES-2:0], kick_input};
		kick_prev_nxt = kick_sync_r[WDS_SYNC_STAGES-1];
		kick_edge     = kick_sync_r[WDS_SYNC_STAGES-1] ^ kick_prev_r;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			kick_sync_r <= '0;
			kick_prev_r <= 1'b0;
		end
		else
		begin
			kick_sync_r <= kick_sync_nxt;
			kick_prev_r <= kick_prev_nxt;
		end
	end

	// without the power-on load the hold timer would sit at zero forever
	// and the reset output would never release
	assign rst_load = reset_trigger || pwr_start_r;

	// reset hold: a trigger of any length restarts the full hold time
	wds_period_timer #(
		.CNT_W   (CNT_W)
	) u_rst_timer (
		.clock   (clock),
		.rst_n   (rst_n),
		.period  (RP_CYCLES),
		.restart (rst_load),
		.hold    (1'b0),
		.done    (rst_done)
	);

	always_comb
	begin
		rst_hold_nxt  = rst_hold_r;
		pwr_start_nxt = 1'b0;
		if (reset_trigger)
		begin
			rst_hold_nxt = 1'b1;
		end
		else if (rst_done)
		begin
			rst_hold_nxt = 1'b0;
		end
		reset_out_nxt = !rst_hold_nxt;
	end

	// watchdog timer is held at full period while reset is asserted,
	// so the first period begins on the release edge
	wds_period_timer #(
		.CNT_W   (CNT_W)
	) u_wd_timer (
		.clock   (clock),
		.rst_n   (rst_n),
		.period  (WD_CYCLES),
		.restart (kick_edge),
		.hold    (rst_hold_r),
		.done    (wd_done)
	);

	always_comb
	begin
		fault_nxt = fault_r;
		// follows the next hold value so fault rises with the reset edge
		if (rst_hold_nxt)
		begin
			fault_nxt = 1'b1;
		end
		else if (kick_edge)
		begin
			fault_nxt = 1'b1;
		end
		else if (wd_done)
		begin
			fault_nxt = 1'b0;
		end
	end

	// power-on counts as a reset trigger: outputs start in reset
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_hold_r  <= 1'b1;
			pwr_start_r <= 1'b1;
			reset_out_r <= 1'b0;
			fault_r     <= 1'b1;
		end
		else
		begin
			rst_hold_r  <= rst_hold_nxt;
			pwr_start_r <= pwr_start_nxt;
			reset_out_r <= reset_out_nxt;
			fault_r     <= fault_nxt;
		end
	end
endmodule
`default_nettype wire

// *** test/wds_properties.sv ***
/* supervisor port assertions; bound onto every supervisor */
`timescale 1ns/1ns
`default_nettype none
module wds_properties #(parameter int unsigned WD_CYCLES = 40) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic kick_input,
	input wire logic reset_trigger,
	input wire logic supervisor_reset_n,
	input wire logic watchdog_fault_n
);
	wire logic rn = supervisor_reset_n;
	wire logic fn = watchdog_fault_n;
	wire logic t = reset_trigger;
	wire logic k = kick_input;
	int unsigned q_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// quiet cycles: reset released, kick line unchanged
	always_ff @(posedge clock)
		q_r <= (!rst_n || !rn || $changed(k)) ? 0 : q_r + 1;
	sequence quiet; $stable(k)[*4]; endsequence
	chk_trig_rst: assert property
		(t |-> ##[1:2] !rn) else $error("no reset");
	chk_rst_hold: assert property
		(t |-> ##2 !rn[*8]) else $error("short reset");
	chk_rst_fault: assert property
		(!rn |-> fn) else $error("fault in reset");
	chk_rst_end: assert property
		($rose(rn) |-> fn[*8]) else $error("early fault");
	chk_kick_clr: assert property
		($changed(k) && !fn |-> ##[1:4] fn) else $error("kick lost");
	chk_fault_hold: assert property
		(quiet ##0 (!fn && !t) |=> !fn) else $error("fault lost");
	chk_wd_early: assert property
		(q_r > 4 && q_r < WD_CYCLES |-> fn) else $error("early expiry");
	chk_wd_expire: assert property
		(q_r == WD_CYCLES + 8 |-> !fn) else $error("no expiry");
endmodule
bind wds_watchdog_supervisor wds_properties #(.WD_CYCLES(WD_CYCLES)) u_chk (
	.clock, .rst_n, .kick_input, .reset_trigger,
	.supervisor_reset_n, .watchdog_fault_n);
`default_nettype wire

// *** test/wds_cpu_model.sv ***
/* processor model toggling its kick line; bench sets enable and gap */
`timescale 1ns/1ns
`default_nettype none
module wds_cpu_model (
	input  wire logic       clock,
	input  wire logic       kick_en,
	input  wire logic [7:0] gap,
	input  wire logic       supervisor_reset_n,
	input  wire logic       watchdog_fault_n,
	output var  logic       kick_input,
	output wire logic       cpu_reset_n
);
	// processor reset pin: gate so a low on either output dominates
	assign cpu_reset_n = supervisor_reset_n & watchdog_fault_n;
	logic [7:0] cnt_r = 8'h00;
	initial kick_input = 1'h0;
	// a gap under the period keeps the fault away
	always @(posedge clock)
	begin
		cnt_r <= (kick_en && cnt_r < gap) ? cnt_r + 8'h01 : 8'h00;
		if (kick_en && cnt_r >= gap)
			kick_input <= ~kick_input;
	end
endmodule
`default_nettype wire

// *** test/wds_watchdog_supervisor_bench.sv ***
/* supervisor bench; assumes 40 and 10 cycle periods */
`timescale 1ns/1ns
`default_nettype none
module wds_watchdog_supervisor_bench;
	localparam int WD = 40, RP = 10;
	logic clock = 1'h0, rst_n = 1'h0, reset_trigger = 1'h0, kick_en = 1'h0;
	logic [7:0] gap = 8'h10;
	wire logic kick_input, supervisor_reset_n, watchdog_fault_n, cpu_reset_n;
	int fails = 0, tests_run = 0;
	wds_watchdog_supervisor #(.WD_CYCLES(WD), .RP_CYCLES(RP))
		u_wds_watchdog_supervisor (.clock, .rst_n, .kick_input,
		.reset_trigger, .supervisor_reset_n, .watchdog_fault_n);
	wds_cpu_model u_wds_cpu_model (.clock, .kick_en, .gap, .kick_input,
		.supervisor_reset_n, .watchdog_fault_n, .cpu_reset_n);
	initial forever #20 clock = ~clock;
	task automatic chk(input string n, input logic e, input logic s);
		tests_run++;
		fails += int'(s !== e);
		if (s !== e)
			$display("MISMATCH %s exp %b got %b", n, e, s);
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge clock);
	endtask
	// outputs are looked at mid-cycle, well after they settle
	task automatic settle();
		@(negedge clock);
	endtask
	task automatic complete_run(input int late);
		fails += late;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial #100000 complete_run(1);
	initial
	begin
		void'($urandom(73));
		run(16);
		rst_n <= 1'h1;
		run(2);
		settle();
		chk("pwr_hold", 1'h0, supervisor_reset_n);
		run(RP + WD + 12);
		settle();
		chk("expire", 1'h0, watchdog_fault_n);
		chk("gated", 1'h0, cpu_reset_n);
		chk("pwr_done", 1'h1, supervisor_reset_n);
		repeat (3)
		begin
			run(1);
			gap <= 8'($urandom_range(5, 30));
			kick_en <= 1'h1;
			run(200);
			settle();
			chk("kicked", 1'h1, watchdog_fault_n);
			run(1);
			kick_en <= 1'h0;
			run(WD + 12);
			settle();
			chk("idle", 1'h0, watchdog_fault_n);
		end
		run(1);
		reset_trigger <= 1'h1;
		run(1);
		reset_trigger <= 1'h0;
		run(1);
		settle();
		chk("forced", 1'h1, watchdog_fault_n);
		chk("held", 1'h0, supervisor_reset_n);
		run(RP + 4);
		settle();
		chk("released", 1'h1, supervisor_reset_n);
		chk("fresh", 1'h1, watchdog_fault_n);
		complete_run(0);
	end
endmodule
`default_nettype wire
